// ==== core/ddl_device.sv ====
// Converter end: serial shift register, bit gate and channel latches
`timescale 1ns/1ps
module ddl_device
   import ddl_pkg::*;
(
   // Core clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Link from the host
   ddl_link_if.device       link,
   // Channel latches
   output logic [11:0]      latchA,
   output logic [11:0]      latchB,
   output logic             latchUpdate,
   output logic             lastMode
);

   // ==========================================================
   // Link domain, clocked by falling shift clock edges
   logic [4:0]  bitCount;
   logic [15:0] shiftReg;
   logic        modeStrobed;
   logic [15:0] heldWord;
   logic        heldMode;
   logic        doneToggle;

   wire         shiftClr  = ~link.clear_n;
   wire         countClr  = link.frameN | ~link.clear_n;
   wire         gateOpen  = ~link.frameN
                            & (bitCount != BIT_COUNT_END);
   wire         firstBit  = gateOpen & (bitCount == BIT_COUNT_FIRST);
   wire         lastBit   = gateOpen & (bitCount == BIT_COUNT_LAST);
   wire [15:0]  nextShift = {shiftReg[14:0], link.serial_in};

   // Frame high holds the counter at zero, so each new frame starts
   // at bit zero whether the clock bursts or runs free
   always_ff @(negedge link.sclk or posedge countClr) begin
      if (countClr) begin
         bitCount <= BIT_COUNT_FIRST;
      end else if (gateOpen) begin
         bitCount <= bitCount + 5'h01;
      end
   end

   always_ff @(negedge link.sclk or posedge shiftClr) begin
      if (shiftClr) begin
         shiftReg <= WORD_RST;
      end else if (gateOpen) begin
         shiftReg <= nextShift;
      end
   end

   always_ff @(negedge link.sclk or posedge shiftClr) begin
      if (shiftClr) begin
         modeStrobed <= 1'b0;
      end else if (firstBit) begin
         modeStrobed <= link.latch_load_n;
      end
   end

   // Completed word is parked and announced by a toggle; it stays
   // stable for at least sixteen clocks, long enough to cross
   always_ff @(negedge link.sclk or posedge shiftClr) begin
      if (shiftClr) begin
         heldWord   <= WORD_RST;
         heldMode   <= 1'b0;
         doneToggle <= 1'b0;
      end else if (lastBit) begin
         heldWord   <= nextShift;
         heldMode   <= modeStrobed;
         doneToggle <= ~doneToggle;
      end
   end

   // ==========================================================
   // Core domain crossing: two flip-flops per level
   logic [2:0]  syncA;
   logic [2:0]  syncB;
   logic        toggleSeen;
   logic        strobeSeen;
   logic        clearSeen;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         syncA <= SYNC_RST;
         syncB <= SYNC_RST;
      end else begin
         syncA <= {link.latch_load_n, link.clear_n, doneToggle};
         syncB <= syncA;
      end
   end

   wire         toggleNow  = syncB[0];
   wire         clearNowN  = syncB[1];
   wire         strobeNow  = syncB[2];

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         toggleSeen <= 1'b0;
         strobeSeen <= 1'b1;
         clearSeen  <= 1'b1;
      end else begin
         toggleSeen <= toggleNow;
         strobeSeen <= strobeNow;
         clearSeen  <= clearNowN;
      end
   end

   // ==========================================================
   // Update decode
   // A clear also flips the toggle back; the event it causes is
   // dropped while the clear is seen, on this or the last cycle
   wire         clearing   = ~clearNowN | ~clearSeen;
   wire         wordEvent  = (toggleNow != toggleSeen) & ~clearing;
   wire         strobeFall = strobeSeen & ~strobeNow & ~clearing;
   wire         selB       = heldWord[SEL_POS];
   wire [11:0]  wordData   = heldWord[DATA_MSB:0];
   wire         autoLoad   = wordEvent & ~heldMode;
   wire         autoA      = autoLoad & ~selB;
   wire         autoB      = autoLoad & selB;
   wire         pendA_we   = wordEvent & ~selB;
   wire         pendB_we   = wordEvent & selB;

   // ==========================================================
   // Channel latches, each fed from the shared shift register
   logic [11:0] pendA;
   logic [11:0] pendB;

   wire [11:0]  next_pendA  = pendA_we ? wordData : pendA;
   wire [11:0]  next_pendB  = pendB_we ? wordData : pendB;
   wire [11:0]  next_latchA = autoA      ? wordData    :
                              strobeFall ? next_pendA  : latchA;
   wire [11:0]  next_latchB = autoB      ? wordData    :
                              strobeFall ? next_pendB  : latchB;

   always_ff @(posedge core_clk) begin
      if (!reset_n || clearing) begin
         pendA <= LATCH_RST;
         pendB <= LATCH_RST;
      end else begin
         pendA <= next_pendA;
         pendB <= next_pendB;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n || clearing) begin
         latchA <= LATCH_RST;
         latchB <= LATCH_RST;
      end else begin
         latchA <= next_latchA;
         latchB <= next_latchB;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         latchUpdate <= 1'b0;
         lastMode    <= 1'b0;
      end else begin
         latchUpdate <= autoLoad | strobeFall;
         lastMode    <= wordEvent ? heldMode : lastMode;
      end
   end

endmodule : ddl_device

// ==== core/ddl_host.sv ====
// Host end: serial port that frames, clocks and loads words
`timescale 1ns/1ps
module ddl_host
   import ddl_pkg::*;
(
   // Core clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Link to the converter
   ddl_link_if.host         link,
   // User requests
   input  wire logic        sendReq,
   input  wire logic        sendChanB,
   input  wire logic [11:0] sendData,
   input  wire logic        sendStrobed,
   input  wire logic        loadReq,
   input  wire logic        clearReq,
   // Status
   output logic             busy
);

   // ==========================================================
   // Sequencer
   ddl_state_t  state;
   logic [4:0]  phase;
   logic [4:0]  bitIdx;
   logic [15:0] word;
   logic        sclkOut;
   logic        frameOut;
   logic        dataOut;
   logic        loadOut;
   logic        clearOut;

   wire         phaseEnd  = (phase == HALF_CNT_LAST);
   wire         clearEnd  = (phase == CLEAR_CNT_LAST);
   wire         lastHost  = (bitIdx == BIT_COUNT_LAST);
   wire [15:0]  newWord   = {3'b000, sendChanB, sendData};
   wire [4:0]   nextPhase = phase + 5'h01;
   wire [4:0]   nextBit   = bitIdx + 5'h01;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state    <= DDL_IDLE;
         phase    <= PHASE_RST;
         bitIdx   <= BIT_COUNT_FIRST;
         word     <= WORD_RST;
         sclkOut  <= 1'b1;
         frameOut <= 1'b1;
         dataOut  <= 1'b0;
         loadOut  <= 1'b1;
         clearOut <= 1'b1;
      end else begin
         case (state)
            DDL_IDLE: begin
               phase <= PHASE_RST;
               if (clearReq) begin
                  clearOut <= 1'b0;
                  state    <= DDL_CLEAR;
               end else if (sendReq) begin
                  word     <= newWord;
                  dataOut  <= newWord[WORD_BITS-1];
                  loadOut  <= sendStrobed;
                  frameOut <= 1'b0;
                  bitIdx   <= BIT_COUNT_FIRST;
                  state    <= DDL_SETUP;
               end else if (loadReq && loadOut) begin
                  loadOut  <= 1'b0;
                  state    <= DDL_LOAD;
               end
            end
            DDL_SETUP: begin
               phase <= phaseEnd ? PHASE_RST : nextPhase;
               if (phaseEnd) begin
                  sclkOut <= 1'b0;
                  state   <= DDL_LOW;
               end
            end
            DDL_LOW: begin
               phase <= phaseEnd ? PHASE_RST : nextPhase;
               if (phaseEnd) begin
                  sclkOut <= 1'b1;
                  word    <= {word[14:0], 1'b0};
                  // Data moves on the rising edge, never with the
                  // sampling edge, so it is settled half a period early
                  dataOut <= word[WORD_BITS-2];
                  state   <= DDL_HIGH;
               end
            end
            DDL_HIGH: begin
               phase <= phaseEnd ? PHASE_RST : nextPhase;
               if (phaseEnd && lastHost) begin
                  frameOut <= 1'b1;
                  state    <= DDL_END;
               end else if (phaseEnd) begin
                  bitIdx  <= nextBit;
                  sclkOut <= 1'b0;
                  state   <= DDL_LOW;
               end
            end
            DDL_END: begin
               phase <= phaseEnd ? PHASE_RST : nextPhase;
               if (phaseEnd) begin
                  state <= DDL_IDLE;
               end
            end
            DDL_LOAD: begin
               phase <= phaseEnd ? PHASE_RST : nextPhase;
               if (phaseEnd) begin
                  loadOut <= 1'b1;
                  state   <= DDL_IDLE;
               end
            end
            DDL_CLEAR: begin
               phase <= clearEnd ? PHASE_RST : nextPhase;
               if (clearEnd) begin
                  clearOut <= 1'b1;
                  state    <= DDL_IDLE;
               end
            end
            default: begin
               state <= DDL_IDLE;
            end
         endcase
      end
   end

   assign link.sclk         = sclkOut;
   assign link.frameN       = frameOut;
   assign link.serial_in    = dataOut;
   assign link.latch_load_n = loadOut;
   assign link.clear_n      = clearOut;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         busy <= 1'b0;
      end else begin
         busy <= (state != DDL_IDLE) | sendReq | clearReq
                 | (loadReq & loadOut);
      end
   end

endmodule : ddl_host

// ==== dv/ddl_link_properties.sv ====
// Concurrent checks on the serial load link and the device latches
`timescale 1ns/1ps
module ddl_link_properties (
   // Core clock and reset
   input wire logic        core_clk,
   input wire logic        reset_n,
   // Link signals
   input wire logic        sclk,
   input wire logic        frameN,
   input wire logic        serial_in,
   input wire logic        latch_load_n,
   input wire logic        clear_n,
   // Device latches
   input wire logic [11:0] latchA,
   input wire logic [11:0] latchB,
   input wire logic        latchUpdate
);
   logic       sclkQ;
   logic [4:0] fallCnt;
   wire        sclkFall = sclkQ & ~sclk;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // Falling shift edges in the current frame
   always_ff @(posedge core_clk) begin
      sclkQ   <= sclk;
      fallCnt <= (!reset_n || frameN) ? 5'h00 : fallCnt + {4'h0, sclkFall};
   end
   // ==========================================================
   // Link and latch rules
   sclk_idle_a: assert property (frameN |-> sclk)
      else $error("shift clock low outside a frame");
   frame_count_a: assert property ($rose(frameN) |-> fallCnt == 5'h10)
      else $error("frame ended without sixteen falling edges");
   clear_width_a: assert property ($fell(clear_n) |-> !clear_n [*4])
      else $error("clear pulse too short");
   clear_zero_a: assert property ($fell(clear_n) |->
      ##[1:8] (latchA == 12'h000 && latchB == 12'h000))
      else $error("latches not zeroed by clear");
   pulse_one_a: assert property (latchUpdate |=> !latchUpdate)
      else $error("update pulse longer than one cycle");
   auto_update_a: assert property ((sclkFall && fallCnt == 5'h0F &&
      !latch_load_n) |-> ##[2:8] latchUpdate)
      else $error("no automatic update after sixteenth edge");
   strobe_load_a: assert property (($fell(latch_load_n) && frameN) |->
      ##[2:8] latchUpdate)
      else $error("no update after latch load strobe");
   hold_strobed_a: assert property ((!frameN && latch_load_n) |=>
      ($stable(latchA) && $stable(latchB)))
      else $error("latch moved during a strobed frame");
   data_hold_a: assert property ((sclkFall && !frameN) |->
      $stable(serial_in))
      else $error("serial data changed at a falling shift edge");
   // Main scenarios reached
   cover property (sclkFall && fallCnt == 5'h0F && !latch_load_n);
   cover property ($fell(latch_load_n) && frameN);
   cover property ($fell(clear_n));
endmodule : ddl_link_properties

// ==== dv/test_dual_dac_serial_load_logic.sv ====
// Self-checking bench for the host and converter ends of the link
`timescale 1ns/1ps
module test_dual_dac_serial_load_logic;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        sendReq = 1'b0;
   logic        sendChanB = 1'b0;
   logic        sendStrobed = 1'b0;
   logic        loadReq = 1'b0;
   logic        clearReq = 1'b0;
   logic [11:0] sendData = 12'h000;
   logic        busy, latchUpdate, lastMode;
   logic [11:0] latchA, latchB, latchA2, latchB2;
   int          error_cnt = 0;
   int          checks_done = 0;
   ddl_link_if link ();
   ddl_link_if link2 ();
   always #12.5 core_clk = ~core_clk;
   ddl_host ddl_host_i (.core_clk(core_clk), .reset_n(reset_n),
      .link(link.host), .sendReq(sendReq), .sendChanB(sendChanB),
      .sendData(sendData), .sendStrobed(sendStrobed),
      .loadReq(loadReq), .clearReq(clearReq), .busy(busy));
   ddl_device ddl_device_i (.core_clk(core_clk), .reset_n(reset_n),
      .link(link.device), .latchA(latchA), .latchB(latchB),
      .latchUpdate(latchUpdate), .lastMode(lastMode));
   // Second device faces the bench so frames can be cut short
   ddl_device ddl_device_i2 (.core_clk(core_clk), .reset_n(reset_n),
      .link(link2.device), .latchA(latchA2), .latchB(latchB2),
      .latchUpdate(), .lastMode());
   ddl_link_properties ddl_link_properties_i (.core_clk(core_clk),
      .reset_n(reset_n), .sclk(link.sclk), .frameN(link.frameN),
      .serial_in(link.serial_in), .latch_load_n(link.latch_load_n),
      .clear_n(link.clear_n), .latchA(latchA), .latchB(latchB),
      .latchUpdate(latchUpdate));
   // ==========================================================
   // Shared tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic chk(input string what, input logic [11:0] exp,
                      input logic [11:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic request(ref logic req);
      int i;
      req = 1'b1;
      cyc(1);
      req = 1'b0;
      cyc(2);
      for (i = 0; i < 1000 && busy !== 1'b0; i++) begin
         cyc(1);
      end
      chk("busy", 12'h000, {11'h000, busy});
      cyc(4);
   endtask : request
   task automatic send(input logic chB, input logic [11:0] d,
                       input logic strobed);
      sendChanB = chB;
      sendData = d;
      sendStrobed = strobed;
      request(sendReq);
   endtask : send
   // Link clock made here only within frames, 125 ns period
   task automatic bang(input logic [15:0] w, input int n, input int extra);
      int i;
      link2.frameN = 1'b0;
      for (i = 0; i < n + extra; i++) begin
         link2.serial_in = (i < 16) ? w[15 - i] : ~link2.serial_in;
         #62.5 link2.sclk = 1'b0;
         #62.5 link2.sclk = 1'b1;
      end
      #62.5 link2.frameN = 1'b1;
      link2.serial_in = ~link2.serial_in;
      #500;
   endtask : bang
   // ==========================================================
   // Scenarios
   task automatic t_clear();
      request(clearReq);
      chk("latchA", 12'h000, latchA);
      chk("latchB", 12'h000, latchB);
   endtask : t_clear
   task automatic t_auto();
      send(1'b0, 12'hA5C, 1'b0);
      chk("latchA", 12'hA5C, latchA);
      chk("latchB", 12'h000, latchB);
      chk("lastMode", 12'h000, {11'h000, lastMode});
      send(1'b1, 12'hFFF, 1'b0);
      chk("latchB", 12'hFFF, latchB);
      send(1'b0, 12'h001, 1'b0);
      chk("latchA", 12'h001, latchA);
   endtask : t_auto
   task automatic t_strobed();
      send(1'b0, 12'h123, 1'b1);
      chk("latchA", 12'h001, latchA);
      chk("lastMode", 12'h001, {11'h000, lastMode});
      send(1'b1, 12'h456, 1'b1);
      chk("latchB", 12'hFFF, latchB);
      request(loadReq);
      chk("latchA", 12'h123, latchA);
      chk("latchB", 12'h456, latchB);
      send(1'b1, 12'h800, 1'b0);
      chk("latchB", 12'h800, latchB);
      chk("latchA", 12'h123, latchA);
   endtask : t_strobed
   task automatic t_gate();
      bang(16'hF5A5, 10, 0);
      chk("latchA2", 12'h000, latchA2);
      chk("latchB2", 12'h000, latchB2);
      bang(16'h1ABC, 16, 5);
      chk("latchB2", 12'hABC, latchB2);
      chk("latchA2", 12'h000, latchA2);
      bang(16'hE321, 16, 0);
      chk("latchA2", 12'h321, latchA2);
   endtask : t_gate
   // ==========================================================
   // Verdict, main sequence and watchdog
   task automatic results();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   initial begin
      link2.sclk = 1'b1;
      link2.frameN = 1'b1;
      link2.serial_in = 1'b0;
      link2.latch_load_n = 1'b0;
      link2.clear_n = 1'b0;
      cyc(10);
      reset_n = 1'b1;
      cyc(6);
      link2.clear_n = 1'b1;
      t_clear();
      t_auto();
      t_strobed();
      t_clear();
      t_gate();
      results();
   end
   // Whole run needs about 2400 core cycles
   initial begin
      #400000;
      error_cnt++;
      results();
   end
endmodule : test_dual_dac_serial_load_logic

// ==== pkg/ddl_link_if.sv ====
// Serial link between host port and converter load logic
`timescale 1ns/1ps
interface ddl_link_if;
   logic sclk;
   logic frameN;
   logic serial_in;
   logic latch_load_n;
   logic clear_n;

   modport host (
      output sclk,
      output frameN,
      output serial_in,
      output latch_load_n,
      output clear_n
   );

   modport device (
      input sclk,
      input frameN,
      input serial_in,
      input latch_load_n,
      input clear_n
   );
endinterface : ddl_link_if

// ==== pkg/ddl_pkg.sv ====
// Shared constants for the dual converter serial load link
package ddl_pkg;

   // ==========================================================
   // Word layout
   localparam int          WORD_BITS    = 16;
   localparam int          DATA_BITS    = 12;
   localparam int          SEL_POS      = 12;
   localparam int          DATA_MSB     = 11;
   localparam logic [4:0]  BIT_COUNT_END = 5'h10;
   localparam logic [4:0]  BIT_COUNT_LAST = 5'h0F;
   localparam logic [4:0]  BIT_COUNT_FIRST = 5'h00;

   // ==========================================================
   // Values after reset or clear
   localparam logic [15:0] WORD_RST     = 16'h0000;
   localparam logic [11:0] LATCH_RST    = 12'h000;
   localparam logic [2:0]  SYNC_RST     = 3'b110;

   // ==========================================================
   // Timing
   localparam int          CORE_PERIOD_NS = 25;
   localparam int          SCLK_PERIOD_NS = 500;
   localparam int          CLEAR_TIME_NS  = 100;
   localparam int          SCLK_HALF_CYC  =
      (SCLK_PERIOD_NS + 2 * CORE_PERIOD_NS - 1) / (2 * CORE_PERIOD_NS);
   localparam int          CLEAR_CYC      =
      (CLEAR_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam logic [4:0]  HALF_CNT_LAST  = 5'(SCLK_HALF_CYC - 1);
   localparam logic [4:0]  CLEAR_CNT_LAST = 5'(CLEAR_CYC - 1);
   localparam logic [4:0]  PHASE_RST      = 5'h00;

   // ==========================================================
   // Host sequencer states
   typedef enum logic [2:0] {
      DDL_IDLE  = 3'b000,
      DDL_SETUP = 3'b001,
      DDL_LOW   = 3'b010,
      DDL_HIGH  = 3'b011,
      DDL_END   = 3'b100,
      DDL_LOAD  = 3'b101,
      DDL_CLEAR = 3'b110
   } ddl_state_t;

endpackage : ddl_pkg
